// [verilog/bsic_top.sv]
// Purpose: boot serial command handler for the info and erase commands
// Assumes: receive bytes arrive with an error flag; transmit goes through a fifo
// Notes: the erase itself is external, started and answered by handshake
`timescale 1ns/10ps
`default_nettype none
module bsic_top #(
   parameter logic [31:0] SOFT_ID = 32'h0000_0000,
   parameter logic [95:0] PRODUCT_NAME = {12{8'h20}},
   parameter logic [31:0] PASSWORD_ADDR = 32'h0000_0000,
   parameter logic [31:0] RAM_END = 32'h0000_0000,
   parameter logic [31:0] FLASH_END = 32'h0000_0000,
   parameter logic [15:0] BLOCK_COUNT = 16'h0000,
   parameter logic [287:0] GROUPS = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_error,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic clocked_mode,
   output logic cmd_wait,
   output logic [7:0] ack_code,
   output logic erase_start,
   input wire logic erase_done,
   input wire logic erase_error
);
   typedef enum logic [6:0] {
      ST_MODE = 7'h01,
      ST_CMD = 7'h02,
      ST_ECHO = 7'h04,
      ST_INFO = 7'h08,
      ST_ENABLE = 7'h10,
      ST_ERASE = 7'h20,
      ST_SUM = 7'h40
   } bsic_state_t;

   bsic_state_t state;
   bsic_state_t next_state;
   logic [3:0] prev_nibble;
   logic [6:0] info_idx;
   logic [7:0] sum;
   logic rom_valid;
   logic [7:0] rom_data;
   logic erase_pending;
   logic push;
   logic [7:0] push_data;
   logic fifo_in_ready;

   // receive error only counts in asynchronous mode
   wire rx_bad = rx_error && !clocked_mode;
   wire cmd_known = (rx_data == bsic_pkg::CMD_RAM) || (rx_data == bsic_pkg::CMD_SUM)
                    || (rx_data == bsic_pkg::CMD_INFO) || (rx_data == bsic_pkg::CMD_ERASE);
   wire [7:0] err_rx_ack = {prev_nibble, bsic_pkg::ACK_RX_ERR};
   wire [7:0] err_cmd_ack = {prev_nibble, bsic_pkg::ACK_BAD_CMD};
   // one-hot state decode
   wire in_mode = (state == ST_MODE);
   wire in_cmd = (state == ST_CMD);
   wire in_enable = (state == ST_ENABLE);
   wire in_info = (state == ST_INFO);
   wire in_sum = (state == ST_SUM);
   wire in_erase = (state == ST_ERASE);

   // a byte is taken only while the fifo has room for its answer
   wire take_cmd = in_cmd && rx_valid && fifo_in_ready;
   wire take_en = in_enable && rx_valid && fifo_in_ready;
   wire take_mode = in_mode && rx_valid && fifo_in_ready;

   // rom read runs one ahead; stalls when the fifo is full
   wire info_step = in_info && fifo_in_ready;
   wire info_push = info_step && rom_valid;
   wire info_end = (info_idx == bsic_pkg::INFO_LAST);
   // next address goes out with each push, so the registered read keeps pace
   wire [6:0] rom_addr = (info_push && !info_end) ? info_idx + 7'h01 : info_idx;
   wire [7:0] chk = 8'h00 - sum;

   // accepted bytes that move the state or the remembered nibble
   wire cmd_ok = take_cmd && !rx_bad && cmd_known;
   wire enable_ok = take_en && !rx_bad && (rx_data == bsic_pkg::ERASE_ENABLE);

   // the cycle that carries the start pulse ignores a done level left from before
   wire erase_take = in_erase && erase_done && fifo_in_ready && !erase_pending;
   wire [7:0] erase_ack = erase_error ? bsic_pkg::ERASE_FAIL : bsic_pkg::ERASE_DONE;

   assign cmd_wait = (state == ST_CMD);

   bsic_info_rom #(
      .SOFT_ID(SOFT_ID),
      .PRODUCT_NAME(PRODUCT_NAME),
      .PASSWORD_ADDR(PASSWORD_ADDR),
      .RAM_END(RAM_END),
      .FLASH_END(FLASH_END),
      .BLOCK_COUNT(BLOCK_COUNT),
      .GROUPS(GROUPS)
   ) u_rom (
      .clk(clk),
      .addr(rom_addr),
      .data(rom_data)
   );

   bsic_fifo #(
      .WIDTH(bsic_pkg::BYTE_W),
      .DEPTH(bsic_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );

   // unknown first byte is ignored; controller times out
   wire mode_ok = (rx_data == bsic_pkg::MODE_ASYNC) || (rx_data == bsic_pkg::MODE_CLOCKED);
   // the mode byte also decides whether receive errors are checked
   wire mode_clocked = (rx_data == bsic_pkg::MODE_CLOCKED);
   wire mode_take = take_mode && mode_ok;

   always_comb begin
      next_state = state;
      push = 1'b0;
      push_data = 8'h00;
      case (state)
         ST_MODE: begin
            if (take_mode && mode_ok) begin
               push = 1'b1;
               push_data = rx_data;
               next_state = ST_CMD;
            end
         end
         ST_CMD: begin
            if (take_cmd) begin
               push = 1'b1;
               next_state = ST_CMD;
               if (rx_bad) begin
                  push_data = err_rx_ack;
               end else if (!cmd_known) begin
                  push_data = err_cmd_ack;
               end else begin
                  push_data = rx_data;
                  if (rx_data == bsic_pkg::CMD_INFO) begin
                     next_state = ST_INFO;
                  end else if (rx_data == bsic_pkg::CMD_ERASE) begin
                     next_state = ST_ENABLE;
                  end
               end
            end
         end
         ST_INFO: begin
            if (info_step && rom_valid) begin
               push = 1'b1;
               push_data = rom_data;
               if (info_idx == bsic_pkg::INFO_LAST) begin
                  next_state = ST_SUM;
               end
            end
         end
         ST_SUM: begin
            if (fifo_in_ready) begin
               push = 1'b1;
               push_data = chk;
               next_state = ST_CMD;
            end
         end
         ST_ENABLE: begin
            if (take_en) begin
               push = 1'b1;
               next_state = ST_CMD;
               if (rx_bad) begin
                  push_data = err_rx_ack;
               end else if (rx_data != bsic_pkg::ERASE_ENABLE) begin
                  push_data = err_cmd_ack;
               end else begin
                  push_data = rx_data;
                  next_state = ST_ERASE;
               end
            end
         end
         ST_ERASE: begin
            if (erase_take) begin
               push = 1'b1;
               push_data = erase_ack;
               next_state = ST_CMD;
            end
         end
         default: begin
            next_state = ST_MODE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= ST_MODE;
      end else begin
         state <= next_state;
      end
   end

   // mode held for the whole session
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         clocked_mode <= 1'b0;
      end else if (mode_take) begin
         clocked_mode <= mode_clocked;
      end
   end

   // only an accepted command moves the nibble that error acks repeat
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prev_nibble <= 4'h0;
      end else if (cmd_ok) begin
         prev_nibble <= rx_data[7:4];
      end
   end

   // last queued byte, for the rest of the boot unit
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_code <= 8'h00;
      end else if (push) begin
         ack_code <= push_data;
      end
   end

   // reply table walk; index clears whenever the reply is not running
   always_ff @(posedge clk) begin
      if (!reset_n || !in_info) begin
         info_idx <= 7'h00;
      end else if (info_push && !info_end) begin
         info_idx <= info_idx + 7'h01;
      end
   end

   // registered rom data is first usable one cycle into the reply
   always_ff @(posedge clk) begin
      if (!reset_n || !in_info) begin
         rom_valid <= 1'b0;
      end else if (info_step) begin
         rom_valid <= 1'b1;
      end
   end

   // running sum survives into the checksum state and clears after it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sum <= 8'h00;
      end else if (info_push) begin
         sum <= sum + rom_data;
      end else if (!in_info && !in_sum) begin
         sum <= 8'h00;
      end
   end

   // one cycle start pulse, then wait for the erase engine
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         erase_start <= 1'b0;
      end else begin
         erase_start <= enable_ok;
      end
   end

   // masks the first erase-state cycle, before the engine has seen the start
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         erase_pending <= 1'b0;
      end else begin
         erase_pending <= enable_ok;
      end
   end
endmodule : bsic_top
`default_nettype wire

// [verilog/bsic_pkg.sv]
// Purpose: constants for the boot serial command handler
// Assumes: byte-wide receive and transmit streams from the boot serial channel
// Notes: product-variant values are plain defaults, override per variant
`default_nettype none
package bsic_pkg;
   localparam logic [7:0] MODE_ASYNC = 8'h86;
   localparam logic [7:0] MODE_CLOCKED = 8'h30;
   localparam logic [7:0] CMD_RAM = 8'h10;
   localparam logic [7:0] CMD_SUM = 8'h20;
   localparam logic [7:0] CMD_INFO = 8'h30;
   localparam logic [7:0] CMD_ERASE = 8'h40;
   localparam logic [7:0] ERASE_ENABLE = 8'h54;
   localparam logic [7:0] ERASE_DONE = 8'h4F;
   localparam logic [7:0] ERASE_FAIL = 8'h4C;
   localparam logic [31:0] RAM_START = 32'h2000_0000;
   localparam logic [31:0] FLASH_START = 32'h3F80_0000;
   localparam logic [3:0] ACK_RX_ERR = 4'h8;
   localparam logic [3:0] ACK_BAD_CMD = 4'h1;
   localparam int INFO_BYTES = 88;
   localparam logic [6:0] INFO_LAST = 7'h57;
   localparam int FIFO_DEPTH = 4;
   localparam int BYTE_W = 8;
endpackage : bsic_pkg
`default_nettype wire

// [verilog/bsic_fifo.sv]
// Purpose: small transmit fifo
// Assumes: single clock
// Notes: unregistered read data, straight from the storage array
`timescale 1ns/10ps
`default_nettype none
module bsic_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= next_count;
      end
   end
endmodule : bsic_fifo
`default_nettype wire

// [verilog/bsic_info_rom.sv]
// Purpose: product information reply table, bytes 5 to 92
// Assumes: variant values given as parameters
// Notes: read data registered, one cycle latency
`timescale 1ns/10ps
`default_nettype none
module bsic_info_rom #(
   parameter logic [31:0] SOFT_ID = 32'h0000_0000,
   parameter logic [95:0] PRODUCT_NAME = {12{8'h20}},
   parameter logic [31:0] PASSWORD_ADDR = 32'h0000_0000,
   parameter logic [31:0] RAM_END = 32'h0000_0000,
   parameter logic [31:0] FLASH_END = 32'h0000_0000,
   parameter logic [15:0] BLOCK_COUNT = 16'h0000,
   parameter logic [287:0] GROUPS = '0
) (
   input wire logic clk,
   input wire logic [6:0] addr,
   output logic [7:0] data
);
   // index 0 is reply byte 5; address fields least significant byte first
   logic [703:0] table_bits;
   assign table_bits = {GROUPS, BLOCK_COUNT, FLASH_END,
                        bsic_pkg::FLASH_START, 80'h0, RAM_END, 32'h0,
                        bsic_pkg::RAM_START, PASSWORD_ADDR,
                        PRODUCT_NAME, SOFT_ID};
   always_ff @(posedge clk) begin
      data <= table_bits[{addr, 3'h0} +: 8];
   end
endmodule : bsic_info_rom
`default_nettype wire

// [bench/bsic_sva.sv]
// Purpose: port checker for the boot serial command handler
// Assumes: only one byte is offered while the transmit fifo is empty
// Notes: bound onto bsic_top
`timescale 1ns/10ps
`default_nettype none
module bsic_sva (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_error,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic clocked_mode,
   input wire logic cmd_wait,
   input wire logic [7:0] ack_code,
   input wire logic erase_start,
   input wire logic erase_done,
   input wire logic erase_error
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // an empty fifo guarantees the byte is taken, not dropped
   wire take = cmd_wait && rx_valid && !tx_valid;
   wire good = rx_data inside {8'h10, 8'h20, 8'h30, 8'h40};
   wire err = rx_error && !clocked_mode;
   sequence s_ok;
      erase_start ##[1:8] (erase_done && !erase_error);
   endsequence
   sequence s_fail;
      erase_start ##[1:8] (erase_done && erase_error);
   endsequence
   a_valid_echo: assert property (take && good && !err |=> ack_code == $past(rx_data))
      else $error("valid command not echoed");
   a_rx_err_ack: assert property (take && err |=> ack_code[3:0] == 4'h8)
      else $error("receive error ack wrong");
   a_bad_cmd_ack: assert property (take && !good && !err |=> ack_code[3:0] == 4'h1 && cmd_wait)
      else $error("invalid command ack wrong");
   a_ack_bits_zero: assert property (take |=> ack_code[2:1] == 2'h0)
      else $error("ack bits 1 or 2 set");
   a_mode_echo: assert property ($rose(cmd_wait) && $past(ack_code) == 8'h00 && $past(rx_valid)
      |-> ack_code == $past(rx_data) && clocked_mode == ($past(rx_data) == 8'h30))
      else $error("mode byte echo wrong");
   a_erase_go: assert property (erase_start |-> ack_code == 8'h54 ##1 !erase_start)
      else $error("erase start pulse wrong");
   a_erase_ok: assert property (s_ok |-> ##[0:2] ack_code == 8'h4F)
      else $error("erase success code missing");
   a_erase_fail: assert property (s_fail |-> ##[0:2] ack_code == 8'h4C)
      else $error("erase error code missing");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("transmit byte not held");
endmodule : bsic_sva
bind bsic_top bsic_sva u_sva (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid),
   .rx_data(rx_data), .rx_error(rx_error), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .tx_data(tx_data), .clocked_mode(clocked_mode), .cmd_wait(cmd_wait), .ack_code(ack_code),
   .erase_start(erase_start), .erase_done(erase_done), .erase_error(erase_error));
`default_nettype wire

// [bench/bsic_ctrl_model.sv]
// Purpose: programming controller receive side
// Assumes: bytes collected in order of transfer
// Notes: slow mode takes one byte in three
`timescale 1ns/10ps
`default_nettype none
module bsic_ctrl_model (
   input wire logic clk,
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] got[$];
   int cnt = 0;
   // stalling lets the fifo fill during the long info reply
   always @(posedge clk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      cnt <= cnt + 1;
      tx_ready <= #1 !slow || (cnt % 3 == 0);
   end
endmodule : bsic_ctrl_model
`default_nettype wire

// [bench/test_boot_serial_info_erase_cmds.sv]
// Purpose: self-checking bench for the boot serial command handler
// Assumes: symmetric id and count values, so byte order is judged on addresses
// Notes: rows hold byte, error flag and expected answer
`timescale 1ns/10ps
`default_nettype none
module test_boot_serial_info_erase_cmds;
   function automatic logic [287:0] grp_f();
      for (int i = 0; i < 36; i++) grp_f[8*i+:8] = 8'(i + 1);
   endfunction : grp_f
   localparam logic [95:0] NAME = "ABCD    DCBA";
   localparam logic [31:0] SID = 32'hC3C3C3C3;
   localparam logic [31:0] PW = 32'h3F87FF00;
   localparam logic [31:0] RAM_END = 32'h20003FFF;
   localparam logic [31:0] FLASH_END = 32'h3F83FFFF;
   localparam logic [15:0] BCNT = 16'h0505;
   localparam logic [287:0] GRP = grp_f();
   logic clk, reset_n, rx_valid, rx_error, tx_valid, tx_ready, clocked_mode, cmd_wait;
   logic erase_start, erase_done, erase_error, slow;
   logic [7:0] rx_data, tx_data, ack_code, sum;
   logic [7:0] info[$];
   int mismatches = 0;
   int checks = 0;
   int starts = 0;
   logic [16:0] rows[5] = '{{8'h10, 1'b0, 8'h10}, {8'h20, 1'b0, 8'h20}, {8'h55, 1'b0, 8'h21},
      {8'h10, 1'b1, 8'h28}, {8'h7F, 1'b0, 8'h21}};
   bsic_top #(.SOFT_ID(SID), .PRODUCT_NAME(NAME), .PASSWORD_ADDR(PW), .RAM_END(RAM_END),
      .FLASH_END(FLASH_END), .BLOCK_COUNT(BCNT), .GROUPS(GRP)) u_dut (.clk(clk),
      .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .clocked_mode(clocked_mode),
      .cmd_wait(cmd_wait), .ack_code(ack_code), .erase_start(erase_start),
      .erase_done(erase_done), .erase_error(erase_error));
   bsic_ctrl_model u_ctrl (.clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (erase_start) starts <= starts + 1;
   function void put(input logic [31:0] v, input int n);
      for (int i = 0; i < n; i++) info.push_back(v[8*i+:8]);
   endfunction : put
   task conclude();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task get(input logic [7:0] exp);
      int n;
      n = 0;
      while (u_ctrl.got.size() == 0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk((u_ctrl.got.size() > 0) ? u_ctrl.got.pop_front() : 8'hXX, exp);
   endtask : get
   task offer(input logic [7:0] b, input logic e);
      @(posedge clk);
      #1 rx_valid = 1'b1;
      rx_data = b;
      rx_error = e;
      @(posedge clk);
      #1 rx_valid = 1'b0;
   endtask : offer
   task send(input logic [7:0] b, input logic e, input logic [7:0] exp);
      offer(b, e);
      get(exp);
   endtask : send
   task erase_end(input logic err, input logic [7:0] exp);
      @(posedge clk);
      #1 erase_done = 1'b1;
      erase_error = err;
      repeat (3) @(posedge clk);
      #1 erase_done = 1'b0;
      get(exp);
   endtask : erase_end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
   initial begin
      {reset_n, rx_valid, rx_error, erase_done, erase_error, slow, rx_data} = '0;
      put(SID, 4);
      for (int i = 0; i < 12; i++) put({24'h0, NAME[8*i+:8]}, 1);
      put(PW, 4);
      put(32'h20000000, 4);
      put(32'h0, 4);
      put(RAM_END, 4);
      put(32'h0, 4);
      put(32'h0, 4);
      put(32'h0, 2);
      put(32'h3F800000, 4);
      put(FLASH_END, 4);
      put({16'h0, BCNT}, 2);
      for (int i = 0; i < 36; i++) put({24'h0, GRP[8*i+:8]}, 1);
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      chk({5'h0, tx_valid, cmd_wait, clocked_mode}, 8'h00);
      send(8'h86, 1'b0, 8'h86);
      chk({7'h0, clocked_mode}, 8'h00);
      foreach (rows[i]) send(rows[i][16:9], rows[i][8], rows[i][7:0]);
      send(8'h40, 1'b0, 8'h40);
      send(8'h13, 1'b0, 8'h41);
      send(8'h40, 1'b0, 8'h40);
      send(8'h54, 1'b1, 8'h48);
      send(8'h40, 1'b0, 8'h40);
      send(8'h54, 1'b0, 8'h54);
      erase_end(1'b0, 8'h4F);
      send(8'h40, 1'b0, 8'h40);
      send(8'h54, 1'b0, 8'h54);
      erase_end(1'b1, 8'h4C);
      chk(starts[7:0], 8'h02);
      slow = 1'b1;
      send(8'h30, 1'b0, 8'h30);
      sum = 8'h00;
      foreach (info[i]) begin
         get(info[i]);
         sum = sum + info[i];
      end
      get(8'h00 - sum);
      chk({7'h0, cmd_wait}, 8'h01);
      slow = 1'b0;
      // a second reset must bring back mode detection
      #1 reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      // an unknown first byte gets no answer and leaves mode detection waiting
      offer(8'h55, 1'b0);
      repeat (4) @(posedge clk);
      chk({6'h0, tx_valid, cmd_wait}, 8'h00);
      send(8'h30, 1'b0, 8'h30);
      chk({7'h0, clocked_mode}, 8'h01);
      send(8'h20, 1'b1, 8'h20);
      send(8'h66, 1'b1, 8'h21);
      conclude();
   end
endmodule : test_boot_serial_info_erase_cmds
`default_nettype wire
